/* File: logic/smb_bus_pins.v */
/*
 Pin-level bus, hold, interrupt, port and security-mode logic.
 Assumes a core that issues one bus request at a time and waits for done.
*/
`timescale 1ns/1ps
`default_nettype none
`include "smb_defs.vh"
module smb_bus_pins #(
   parameter AW = `SMB_ADDR_W,
   parameter DW = `SMB_DATA_W
) (
   // Clock and reset
   input  wire          clk,
   input  wire          rst,
   // Core bus request
   input  wire          reqValid,
   input  wire          reqIsIo,
   input  wire          reqWrite,
   input  wire          reqWide,
   input  wire          reqFetch,
   input  wire [AW-1:0] reqAddr,
   input  wire [15:0]   reqWrData,
   output wire          reqReady,
   output reg           reqDone_ff,
   output reg  [15:0]   rspData_ff,
   output wire [DW-1:0] fetchOp,
   // Core mode control
   input  wire          enterSecureInstr,
   input  wire          enterNormalInstr,
   input  wire          tblWrEn,
   input  wire [DW-1:0] tblWrIdx,
   input  wire [DW-1:0] tblWrData,
   output reg           secureMode_ff,
   // Mode strap
   input  wire          modeSelect,
   // External bus pins
   output reg  [AW-1:0] addr_ff,
   output wire          addrOe,
   input  wire [DW-1:0] dataIn,
   output reg  [DW-1:0] dataOut_ff,
   output wire          dataOe,
   output reg           memoryCycleFlag_n_ff,
   output reg           memoryStrobe_n_ff,
   output reg           ioStrobe_n_ff,
   output reg           readWrite_ff,
   output wire          ctlOe,
   output wire          refreshPulse_n,
   // Hold handshake
   input  wire          busHoldRequest,
   output reg           busHoldGrant_n_ff,
   // Interrupts
   input  wire          maskIrq,
   input  wire [DW-1:0] irqVectorIn,
   input  wire          irqEnable,
   output reg           irqGrantOut_n_ff,
   input  wire [2:0]    edgeIrqInputs,
   input  wire [2:0]    edgeRising,
   input  wire          nmiPin,
   input  wire          nmiRising,
   output wire [2:0]    edgeIrqEvent,
   output wire          nmiEvent,
   output wire [DW-1:0] nmiVector,
   output wire          standbyRelease,
   output reg           irqTaken_ff,
   output reg  [DW-1:0] irqVector_ff,
   // Clock out and ports
   output wire          systemClockOut,
   input  wire [7:0]    port0In,
   input  wire [7:0]    port0Dir,
   input  wire [7:0]    port0Wr,
   input  wire          port0ClkSel,
   output wire [7:0]    port0Out,
   output wire [7:0]    port0Oe,
   input  wire [7:0]    port1In,
   input  wire [7:0]    port1Mode,
   input  wire [3:0]    port1Wr,
   input  wire [3:0]    port1Ctl,
   output wire [3:0]    port1Out,
   output wire [3:0]    port1Oe,
   output wire [7:0]    port1Read,
   output wire [7:0]    port0Read
);
   reg [2:0]    state_ff;
   reg [2:0]    nxt_state;
   reg          byteHi_ff;
   reg          strapDone_ff;
   reg          fetch_ff;
   reg          wide_ff;
   reg          io_ff;
   reg [15:0]   wd_ff;
   wire         released;
   wire [DW-1:0] xlated;

   assign reqReady = (state_ff == `SMB_ST_IDLE) && !busHoldRequest
                     && !(maskIrq && irqEnable);
   assign released = (state_ff == `SMB_ST_HOLD);
   // Pins float while released; pull-ups live in the pad
   assign addrOe = !released; // R10
   assign ctlOe  = !released; // R10
   assign dataOe = !released && !readWrite_ff
                   && (state_ff == `SMB_ST_STROBE); // R7
   assign refreshPulse_n = 1'b1;
   assign systemClockOut = clk; // R8
   assign nmiVector = `SMB_NMI_VECTOR; // R15

   // Mode: strap caught once after reset, then instructions rule
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         secureMode_ff <= 1'b0;
         strapDone_ff  <= 1'b0;
      end else if (!strapDone_ff) begin
         strapDone_ff  <= 1'b1;
         secureMode_ff <= (modeSelect == `SMB_MODE_SECURE); // R5
      end else if (enterSecureInstr) begin
         secureMode_ff <= 1'b1; // R3 R4
      end else if (enterNormalInstr) begin
         secureMode_ff <= 1'b0; // R3 R4
      end
   end

   smb_opcode_xlate #(.DW(DW)) uXlate (
      .clk       (clk),
      .rst       (rst),
      .tblWrEn   (tblWrEn),
      .tblWrIdx  (tblWrIdx),
      .tblWrData (tblWrData),
      .secure    (secureMode_ff),
      .rawOp     (rspData_ff[7:0]),
      .execOp    (xlated)
   );
   assign fetchOp = fetch_ff ? xlated : rspData_ff[7:0]; // R1

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : gEdge
         smb_edge_detect uEdge (
            .clk       (clk),
            .rst       (rst),
            .pinIn     (edgeIrqInputs[g]),
            .risingSel (edgeRising[g]),
            .edgeSeen  (edgeIrqEvent[g]) // R14
         );
      end
   endgenerate
   smb_edge_detect uNmi (
      .clk       (clk),
      .rst       (rst),
      .pinIn     (nmiPin),
      .risingSel (nmiRising),
      .edgeSeen  (nmiEvent) // R15 R16
   );
   assign standbyRelease = nmiEvent; // R16

   // Bus sequencer
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         `SMB_ST_IDLE: begin
            if (busHoldRequest) begin
               nxt_state = `SMB_ST_HOLD; // R9
            end else if (maskIrq && irqEnable) begin
               nxt_state = `SMB_ST_INTA; // R12
            end else if (reqValid) begin
               nxt_state = `SMB_ST_ADDR;
            end
         end
         `SMB_ST_ADDR:   nxt_state = `SMB_ST_STROBE;
         `SMB_ST_STROBE: nxt_state = `SMB_ST_DONE;
         `SMB_ST_DONE: begin
            if (wide_ff && !byteHi_ff) begin
               nxt_state = `SMB_ST_ADDR; // R7
            end else begin
               nxt_state = `SMB_ST_IDLE;
            end
         end
         `SMB_ST_HOLD: begin
            if (!busHoldRequest) begin
               nxt_state = `SMB_ST_IDLE;
            end
         end
         `SMB_ST_INTA: nxt_state = `SMB_ST_IDLE;
         default: nxt_state = `SMB_ST_IDLE;
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff             <= `SMB_ST_IDLE;
         byteHi_ff            <= 1'b0;
         fetch_ff             <= 1'b0;
         wide_ff              <= 1'b0;
         io_ff                <= 1'b0;
         wd_ff                <= 16'h0000;
         addr_ff              <= {AW{1'b0}};
         dataOut_ff           <= {DW{1'b0}};
         memoryCycleFlag_n_ff <= 1'b1;
         memoryStrobe_n_ff    <= 1'b1;
         ioStrobe_n_ff        <= 1'b1;
         readWrite_ff         <= 1'b1;
         busHoldGrant_n_ff    <= 1'b1;
         irqGrantOut_n_ff     <= 1'b1;
         irqTaken_ff          <= 1'b0;
         irqVector_ff         <= {DW{1'b0}};
         reqDone_ff           <= 1'b0;
         rspData_ff           <= 16'h0000;
      end else begin
         state_ff         <= nxt_state;
         reqDone_ff       <= 1'b0;
         irqTaken_ff      <= 1'b0;
         busHoldGrant_n_ff <= !(nxt_state == `SMB_ST_HOLD); // R11
         irqGrantOut_n_ff <= !(nxt_state == `SMB_ST_INTA); // R13
         case (state_ff)
            `SMB_ST_IDLE: begin
               if (nxt_state == `SMB_ST_ADDR) begin
                  addr_ff      <= reqAddr; // R6
                  io_ff        <= reqIsIo;
                  wide_ff      <= reqWide;
                  fetch_ff     <= reqFetch;
                  wd_ff        <= reqWrData;
                  byteHi_ff    <= 1'b0;
                  readWrite_ff <= !reqWrite; // R20
                  memoryCycleFlag_n_ff <= reqIsIo; // R17
                  dataOut_ff   <= reqWrData[7:0];
               end
            end
            `SMB_ST_ADDR: begin
               memoryStrobe_n_ff <= io_ff; // R18
               ioStrobe_n_ff     <= !io_ff; // R19
            end
            `SMB_ST_STROBE: begin
               memoryStrobe_n_ff <= 1'b1;
               ioStrobe_n_ff     <= 1'b1;
               if (byteHi_ff) begin
                  rspData_ff[15:8] <= dataIn;
               end else begin
                  rspData_ff[7:0] <= dataIn;
               end
            end
            `SMB_ST_DONE: begin
               if (nxt_state == `SMB_ST_ADDR) begin
                  byteHi_ff  <= 1'b1;
                  addr_ff    <= addr_ff + {{(AW-1){1'b0}}, 1'b1}; // R7
                  dataOut_ff <= wd_ff[15:8];
               end else begin
                  reqDone_ff <= 1'b1;
                  memoryCycleFlag_n_ff <= 1'b1;
                  readWrite_ff <= 1'b1;
               end
            end
            `SMB_ST_INTA: begin
               irqTaken_ff  <= 1'b1;
               irqVector_ff <= irqVectorIn; // R12
            end
            default: begin
            end
         endcase
      end
   end

   // Ports
   genvar p;
   generate
      for (p = 0; p < 4; p = p + 1) begin : gP1
         wire [1:0] m = port1Mode[2*p+1:2*p];
         assign port1Out[p] = (m == `SMB_P1_CTL) ? port1Ctl[p]
                                                 : port1Wr[p]; // R23
         assign port1Oe[p]  = (m == `SMB_P1_OUT) || (m == `SMB_P1_CTL);
      end
   endgenerate
   assign port1Read = port1In; // R22
   assign port0Out  = {port0ClkSel ? clk : port0Wr[7], port0Wr[6:0]}; // R21
   assign port0Oe   = {port0ClkSel | port0Dir[7], port0Dir[6:0]}; // R21
   assign port0Read = port0In;
endmodule // smb_bus_pins
`default_nettype wire

/* File: logic/smb_defs.vh */
/*
 Constants for the secure bus/pin interface block.
 Assumes a 25 MHz system clock and an inferred-width core command port.
*/
// Function
// R1: In security mode, fetched opcodes pass through the user translation table.
// R2: Translation is combinational; fetch timing matches normal mode.
// R3: Mode settable by strap, by software, or both, at any time; the strap is sampled only once, after reset.
// R4: Two instructions: one enters secure mode, one enters normal mode.
// R5: Mode pin sampled at reset: high normal, low secure; held fixed.
// R6: Drive a 20-bit address bus for every external access.
// R7: 8-bit bidirectional data bus; 16-bit operands take two transfers.
// R8: Drive the internal system clock onto a clock output pin.
// R9: Hold request input high asks the device to release the bus.
// R10: Released bus: address, data, strobes, refresh in high impedance; refresh pin has no enable and is driven high always.
// R11: Hold grant output goes low when the bus is released.
// R12: Maskable request is active high; external hardware supplies the vector.
// R13: Interrupt grant output goes low once the maskable request is granted.
// R14: Each of three edge interrupt inputs picks rising or falling edge.
// R15: Non-maskable interrupt ignores masking and uses vector number 2.
// R16: Non-maskable interrupt releases standby; its edge is programmable.
// R17: Memory cycle flag is low during every memory bus cycle.
// R18: Memory strobe, active low, during memory reads and writes.
// R19: I/O strobe asserted during I/O reads and writes.
// R20: Read/write output marks each bus cycle as read or write.
// R21: Port 0 is eight lines, direction per bit; top line may carry clock.
// R22: Port 1 low four lines are always control but readable as data.
// R23: Each upper port 1 line is input, output or control function.
`ifndef SMB_DEFS_VH
`define SMB_DEFS_VH
`define SMB_ADDR_W       20
`define SMB_DATA_W       8
`define SMB_NMI_VECTOR   8'h02
`define SMB_ST_IDLE      3'h0
`define SMB_ST_ADDR      3'h1
`define SMB_ST_STROBE    3'h2
`define SMB_ST_DONE      3'h3
`define SMB_ST_HOLD      3'h4
`define SMB_ST_INTA      3'h5
`define SMB_P1_IN        2'h0
`define SMB_P1_OUT       2'h1
`define SMB_P1_CTL       2'h2
`define SMB_MODE_SECURE  1'b0
`define SMB_MODE_NORMAL  1'b1
`endif

/* File: logic/smb_edge_detect.v */
/*
 One programmable-edge interrupt detector.
 Assumes input already synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module smb_edge_detect (
   // Clock and reset
   input  wire clk,
   input  wire rst,
   // Pin and polarity
   input  wire pinIn,
   input  wire risingSel,
   // Event
   output wire edgeSeen
);
   reg prevPin_ff;
   reg primed_ff;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         prevPin_ff <= 1'b0;
         primed_ff  <= 1'b0;
      end else begin
         prevPin_ff <= pinIn;
         primed_ff  <= 1'b1;
      end
   end
   // Polarity picks which transition counts; nothing counts until a
   // real sample is held, so a pin idling high gives no edge after reset
   assign edgeSeen = primed_ff & (risingSel ? (pinIn & ~prevPin_ff)
                                            : (~pinIn & prevPin_ff)); // R14 R16
endmodule // smb_edge_detect
`default_nettype wire

/* File: logic/smb_opcode_xlate.v */
/*
 Opcode translation table, written by software, read combinationally.
 Assumes table loads happen while no fetch depends on the entry written.
*/
`timescale 1ns/1ps
`default_nettype none
module smb_opcode_xlate #(
   parameter DW = 8
) (
   // Clock and reset
   input  wire          clk,
   input  wire          rst,
   // Table load
   input  wire          tblWrEn,
   input  wire [DW-1:0] tblWrIdx,
   input  wire [DW-1:0] tblWrData,
   // Lookup
   input  wire          secure,
   input  wire [DW-1:0] rawOp,
   output wire [DW-1:0] execOp
);
   localparam N = 1 << DW;
   reg [DW-1:0] table_ff [0:N-1];
   integer i;
   // Reset to identity so an unloaded table is harmless
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < N; i = i + 1) begin
            table_ff[i] <= i[DW-1:0];
         end
      end else if (tblWrEn) begin
         table_ff[tblWrIdx] <= tblWrData;
      end
   end
   // No register in the path: no extra fetch cycle
   assign execOp = secure ? table_ff[rawOp] : rawOp; // R1 R2
endmodule // smb_opcode_xlate
`default_nettype wire

/* File: tb/smb_bus_pins_properties.sv */
/*
 Checker for the bus pin block: cycles, hold, interrupts and mode.
 Assumes a bind into smb_bus_pins with matching port names.
*/
`timescale 1ns/1ps
`default_nettype none
module smb_bus_pins_properties (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Core side
   input wire logic       reqValid,
   input wire logic       reqIsIo,
   input wire logic       reqWrite,
   input wire logic       reqReady,
   input wire logic       enterSecureInstr,
   input wire logic       enterNormalInstr,
   input wire logic       secureMode_ff,
   input wire logic       modeSelect,
   // Bus pins
   input wire logic       addrOe,
   input wire logic       dataOe,
   input wire logic       ctlOe,
   input wire logic       memoryCycleFlag_n_ff,
   input wire logic       memoryStrobe_n_ff,
   input wire logic       ioStrobe_n_ff,
   input wire logic       readWrite_ff,
   input wire logic       busHoldRequest,
   input wire logic       busHoldGrant_n_ff,
   // Interrupts
   input wire logic       maskIrq,
   input wire logic       irqEnable,
   input wire logic       irqGrantOut_n_ff,
   input wire logic       nmiEvent,
   input wire logic       standbyRelease,
   input wire logic [7:0] nmiVector
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_take;
      reqValid && reqReady;
   endsequence
   sequence s_memAccess;
      !memoryCycleFlag_n_ff ##1 !memoryStrobe_n_ff && ioStrobe_n_ff;
   endsequence
   sequence s_ioAccess;
      memoryCycleFlag_n_ff ##1 !ioStrobe_n_ff && memoryStrobe_n_ff;
   endsequence
   property p_memCycle;
      s_take ##0 !reqIsIo |-> ##1 s_memAccess;
   endproperty
   property p_ioCycle;
      s_take ##0 reqIsIo |-> ##1 s_ioAccess;
   endproperty
   property p_rwWrite;
      s_take ##0 reqWrite |-> ##1 (!readWrite_ff)[*3];
   endproperty
   // Data pins follow the cycle direction only while a strobe is low
   property p_dataDrive;
      !memoryStrobe_n_ff || !ioStrobe_n_ff |-> dataOe == !readWrite_ff;
   endproperty
   // Bounded so a stuck hold handshake is seen
   property p_holdGrant;
      $rose(busHoldRequest) |-> ##[0:12] !busHoldGrant_n_ff;
   endproperty
   property p_released;
      !busHoldGrant_n_ff |-> !addrOe && !dataOe && !ctlOe && !reqReady;
   endproperty
   property p_irqGrant;
      $rose(maskIrq && irqEnable) && !busHoldRequest
         |-> ##[0:12] !irqGrantOut_n_ff;
   endproperty
   property p_irqPulse;
      $fell(irqGrantOut_n_ff) |=> irqGrantOut_n_ff;
   endproperty
   property p_nmiVec;
      nmiVector == 8'h02;
   endproperty
   property p_nmiStandby;
      nmiEvent |-> standbyRelease;
   endproperty
   property p_secEnter;
      enterSecureInstr |=> secureMode_ff;
   endproperty
   property p_normEnter;
      enterNormalInstr && !enterSecureInstr |=> !secureMode_ff;
   endproperty
   property p_strap;
      $fell(rst) |=> secureMode_ff == !$past(modeSelect);
   endproperty
   a_memCycle: assert property (p_memCycle)
      else $error("memory cycle flag or strobe out of step");
   a_ioCycle: assert property (p_ioCycle)
      else $error("io strobe out of step");
   a_rwWrite: assert property (p_rwWrite)
      else $error("write cycle not marked as write");
   a_dataDrive: assert property (p_dataDrive)
      else $error("data pins driven in wrong direction");
   a_holdGrant: assert property (p_holdGrant)
      else $error("hold request not granted in time");
   a_released: assert property (p_released)
      else $error("bus still driven while released");
   a_irqGrant: assert property (p_irqGrant)
      else $error("interrupt not granted in time");
   a_irqPulse: assert property (p_irqPulse)
      else $error("interrupt grant longer than one cycle");
   a_nmiVec: assert property (p_nmiVec)
      else $error("nmi vector wrong");
   a_nmiStandby: assert property (p_nmiStandby)
      else $error("nmi did not release standby");
   a_secEnter: assert property (p_secEnter)
      else $error("secure instruction ignored");
   a_normEnter: assert property (p_normEnter)
      else $error("normal instruction ignored");
   a_strap: assert property (p_strap)
      else $error("mode strap not sampled at reset");
endmodule // smb_bus_pins_properties
bind smb_bus_pins smb_bus_pins_properties i_smb_bus_pins_properties (.*);
`default_nettype wire

/* File: tb/smb_ext_mem.sv */
/*
 External memory and I/O model on the far side of the bus pins.
 Assumes the design's strobes are sampled on the rising clock.
*/
`timescale 1ns/1ps
`default_nettype none
module smb_ext_mem (
   // Clock
   input  wire logic        clk,
   // Bus pins
   input  wire logic [19:0] addr_ff,
   input  wire logic        memoryStrobe_n_ff,
   input  wire logic        ioStrobe_n_ff,
   input  wire logic        readWrite_ff,
   input  wire logic        dataOe,
   input  wire logic [7:0]  dataOut_ff,
   output logic      [7:0]  dataIn
);
   logic [7:0]  mem [0:511];
   logic [7:0]  lastData = 8'h00;
   logic [19:0] lastAddr;
   wire  logic  sel = !memoryStrobe_n_ff || !ioStrobe_n_ff;
   // Separate spaces so an I/O cycle can never hit memory
   wire  logic [8:0] idx = {!ioStrobe_n_ff, addr_ff[7:0]};
   // Off-strobe the lines show inverted old data, never a stale match
   always_comb dataIn = (sel && readWrite_ff) ? mem[idx] : ~lastData;
   always @(posedge clk) begin
      if (sel) begin
         lastAddr <= addr_ff;
      end
      if (sel && readWrite_ff) begin
         lastData <= mem[idx];
      end
      if (sel && !readWrite_ff && dataOe) begin
         mem[idx] <= dataOut_ff;
      end
   end
endmodule // smb_ext_mem
`default_nettype wire

/* File: tb/tb.sv */
/*
 Self-checking bench for smb_bus_pins with an external memory model.
 Assumes a 25 MHz clock; inputs change on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk, rst, reqValid, reqIsIo, reqWrite, reqWide, reqFetch;
   logic enterSecureInstr, enterNormalInstr, tblWrEn, modeSelect;
   logic busHoldRequest, maskIrq, irqEnable, port0ClkSel;
   logic [19:0] reqAddr, addr_ff;
   logic [15:0] reqWrData, rspData_ff;
   logic [7:0]  tblWrIdx, tblWrData, dataIn, dataOut_ff, irqVectorIn;
   logic [7:0]  port0In, port0Dir, port0Wr, port0Out, port0Oe, port1In;
   logic [7:0]  port1Mode, port1Read, port0Read, fetchOp, nmiVector;
   logic [7:0]  irqVector_ff;
   logic [3:0]  port1Wr, port1Ctl, port1Out, port1Oe, pins, rises;
   logic [2:0]  edgeIrqEvent;
   logic reqReady, reqDone_ff, secureMode_ff, addrOe, dataOe, ctlOe;
   logic memoryCycleFlag_n_ff, memoryStrobe_n_ff, ioStrobe_n_ff;
   logic readWrite_ff, refreshPulse_n, busHoldGrant_n_ff;
   logic irqGrantOut_n_ff, nmiEvent, standbyRelease, irqTaken_ff;
   logic systemClockOut;
   wire logic [2:0] edgeIrqInputs = pins[2:0];
   wire logic       nmiPin = pins[3];
   wire logic [2:0] edgeRising = rises[2:0];
   wire logic       nmiRising = rises[3];
   wire logic [3:0] ev = {nmiEvent, edgeIrqEvent};
   int failures, samples_checked, lat, cycles;
   smb_bus_pins i_smb_bus_pins (.*);
   smb_ext_mem i_smb_ext_mem (.*);
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checked=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Holds the request through the taking edge; lat counts to done
   task automatic xfer(input logic io, wr, wide, fetch,
                       input logic [19:0] a, input logic [15:0] d);
      int n;
      @(negedge clk);
      {reqIsIo, reqWrite, reqWide, reqFetch} = {io, wr, wide, fetch};
      reqAddr = a;
      reqWrData = d;
      reqValid = 1'b1;
      for (n = 0; reqReady !== 1'b1 && n < 50; n++) @(negedge clk);
      @(negedge clk);
      reqValid = 1'b0;
      for (n = 0; reqDone_ff !== 1'b1 && n < 50; n++) @(negedge clk);
      lat = n;
      chk(n < 50, 1'b1);
   endtask
   task automatic t_mem;
      xfer(0, 1, 0, 0, 20'hABC12, 16'h0055);
      chk(i_smb_ext_mem.lastAddr, 20'hABC12);
      xfer(0, 0, 0, 0, 20'hABC12, 16'h0000);
      chk(rspData_ff[7:0], 8'h55);
      xfer(0, 1, 1, 0, 20'h00020, 16'hBEEF);
      chk(i_smb_ext_mem.lastAddr, 20'h00021);
      xfer(0, 0, 1, 0, 20'h00020, 16'h0000);
      chk(rspData_ff, 16'hBEEF);
      xfer(0, 0, 0, 0, 20'h00021, 16'h0000);
      chk(rspData_ff[7:0], 8'hBE);
      $display("t_mem done");
   endtask
   task automatic t_io;
      xfer(1, 1, 0, 0, 20'h0FF30, 16'h00A5);
      xfer(1, 0, 0, 0, 20'h0FF30, 16'h0000);
      chk(rspData_ff[7:0], 8'hA5);
      $display("t_io done");
   endtask
   task automatic t_hold;
      int n;
      @(negedge clk);
      busHoldRequest = 1'b1;
      for (n = 0; busHoldGrant_n_ff !== 1'b0 && n < 20; n++) @(negedge clk);
      chk(busHoldGrant_n_ff, 1'b0);
      chk({addrOe, dataOe, ctlOe, reqReady}, 4'h0);
      busHoldRequest = 1'b0;
      repeat (3) @(negedge clk);
      chk({busHoldGrant_n_ff, addrOe, ctlOe}, 3'h7);
      chk(refreshPulse_n, 1'b1);
      $display("t_hold done");
   endtask
   task automatic t_irq;
      int n;
      logic saw;
      saw = 1'b0;
      @(negedge clk);
      irqVectorIn = 8'h5A;
      maskIrq = 1'b1;
      repeat (4) @(negedge clk);
      chk(irqGrantOut_n_ff, 1'b1);
      irqEnable = 1'b1;
      for (n = 0; irqTaken_ff !== 1'b1 && n < 20; n++) begin
         @(negedge clk);
         if (irqGrantOut_n_ff === 1'b0) saw = 1'b1;
      end
      maskIrq = 1'b0;
      irqEnable = 1'b0;
      chk(saw, 1'b1);
      chk(irqVector_ff, 8'h5A);
      $display("t_irq done");
   endtask
   task automatic t_edge;
      for (int i = 0; i < 4; i++) begin
         for (int r = 0; r < 2; r++) begin
            @(negedge clk);
            rises[i] = r[0];
            pins[i] = !r[0];
            repeat (2) @(negedge clk);
            pins[i] = r[0];
            #1;
            chk(ev[i], 1'b1);
            @(negedge clk);
            pins[i] = !r[0];
            #1;
            chk(ev[i], 1'b0);
         end
      end
      chk(nmiVector, 8'h02);
      $display("t_edge done");
   endtask
   task automatic t_port;
      @(negedge clk);
      {port0Dir, port0Wr, port0In, port1In} = 32'h0FA53C96;
      {port1Mode, port1Wr, port1Ctl} = 16'h915A;
      #1;
      chk(port0Oe, 8'h0F);
      chk(port0Out[6:0], 7'h25);
      chk(port0Read, 8'h3C);
      chk(port1Read, 8'h96);
      chk(port1Out, 4'hD);
      chk(port1Oe, 4'hD);
      @(negedge clk);
      port0ClkSel = 1'b1;
      @(posedge clk);
      #10;
      chk({port0Out[7], systemClockOut}, 2'h3);
      @(negedge clk);
      #1;
      chk({port0Out[7], systemClockOut}, 2'h0);
      $display("t_port done");
   endtask
   task automatic t_mode;
      int ln;
      chk(secureMode_ff, 1'b0);
      @(negedge clk);
      {tblWrEn, tblWrIdx, tblWrData} = {1'b1, 16'h3CC3};
      @(negedge clk);
      tblWrEn = 1'b0;
      xfer(0, 1, 0, 0, 20'h00040, 16'h003C);
      xfer(0, 0, 0, 1, 20'h00040, 16'h0000);
      ln = lat;
      chk(fetchOp, 8'h3C);
      @(negedge clk);
      enterSecureInstr = 1'b1;
      @(negedge clk);
      enterSecureInstr = 1'b0;
      chk(secureMode_ff, 1'b1);
      xfer(0, 0, 0, 1, 20'h00040, 16'h0000);
      chk(fetchOp, 8'hC3);
      chk(lat, ln);
      enterNormalInstr = 1'b1;
      @(negedge clk);
      enterNormalInstr = 1'b0;
      chk(secureMode_ff, 1'b0);
      // Strap changes only while reset is held
      modeSelect = 1'b0;
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      chk(secureMode_ff, 1'b1);
      $display("t_mode done");
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         summarize;
      end
   end
   initial begin
      {reqValid, reqIsIo, reqWrite, reqWide, reqFetch, tblWrEn} = '0;
      {enterSecureInstr, enterNormalInstr, busHoldRequest} = '0;
      {maskIrq, irqEnable, port0ClkSel, pins, rises} = '0;
      {reqAddr, reqWrData, tblWrIdx, tblWrData, irqVectorIn} = '0;
      {port0In, port0Dir, port0Wr, port1In, port1Mode} = '0;
      {port1Wr, port1Ctl} = '0;
      modeSelect = 1'b1;
      rst = 1'b1;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      t_mem;
      t_io;
      t_hold;
      t_irq;
      t_edge;
      t_port;
      t_mode;
      summarize;
   end
endmodule // tb
`default_nettype wire
